/* File: include/srsd_params.svh */
// field positions, word numbers and reset values of the setup state descriptor
`ifndef SRSD_PARAMS_SVH
`define SRSD_PARAMS_SVH
`define W_FIRST 3'h3
`define W_LAST 3'h7
`define W_VTX 3'h3
`define W_THR 3'h4
`define W_VP 3'h5
`define W_RAS 3'h6
`define W_LIN 3'h7
`define WORD_RST 32'h0000_0000
`define VRL_H 16
`define VRL_L 11
`define VRO_H 9
`define VRO_L 4
`define GRF_H 3
`define GRF_L 0
`define THR_H 30
`define THR_L 25
`define ESZ_H 24
`define ESZ_L 19
`define ECN_H 18
`define ECN_L 11
`define STAT_B 10
`define VPO_H 31
`define VPO_L 5
`define VPX_B 1
`define WIND_B 0
`define AA_B 31
`define CULL_H 30
`define CULL_L 29
`define CAP_H 23
`define CAP_L 22
`define PTR_H 21
`define PTR_L 20
`define SCIS_B 17
`define BX_H 16
`define BX_L 13
`define BY_H 12
`define BY_L 9
`define LPX_B 31
`define TPV_H 30
`define TPV_L 29
`define LPV_H 28
`define LPV_L 27
`define BIAS_ZERO 4'h0
`define BIAS_HALF 4'h8
`endif

/* File: include/setup_pkg.sv */
// shared types of the setup state decode block
`include "srsd_params.svh"
package setup_pkg;
   typedef logic [`W_LAST:`W_FIRST][31:0] desc_t;
   typedef enum logic [1:0] {cull_all, cull_nothing, cull_front_facing, cull_back_facing} cull_e;
   typedef enum logic [1:0] {prim_point, prim_line, prim_tri, prim_rect} prim_e;
   typedef enum logic {tie_rule_top_left, tie_rule_top_right} tie_e;
   typedef enum logic {fence_idle, fence_wait} fence_e;
endpackage : setup_pkg

/* File: include/setup_cfg_if.sv */
// descriptor words and orientation controls passed between the setup decode modules
`timescale 1ns/1ns
`default_nettype none
interface setup_cfg_if;
   import setup_pkg::*;
   desc_t words;
   cull_e cull;
   logic front_ccw;
   logic last_px_en;
   logic [1:0] tri_pv;
   logic [1:0] line_pv;
   modport capture(output words);
   modport judge(input cull, input front_ccw, input last_px_en, input tri_pv, input line_pv);
endinterface : setup_cfg_if
`default_nettype wire

/* File: src/desc_capture.sv */
// holds the five descriptor words written by driver software
`timescale 1ns/1ns
`default_nettype none
module desc_capture (
   input wire logic clk,
   input wire logic reset,
   input wire logic wr,
   input wire logic [2:0] idx,
   input wire logic [31:0] data,
   setup_cfg_if.capture cfg
);
   import setup_pkg::*;
   typedef struct packed {
      desc_t words;
   } cap_s;
   cap_s st_q;
   cap_s st_d;
   always_comb begin
      st_d = st_q;
      // words below the first decoded one are not held here
      if (wr && idx >= `W_FIRST) begin
         st_d.words[idx] = data;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '{words: {5{`WORD_RST}}};
      end else begin
         st_q <= st_d;
      end
   end
   assign cfg.words = st_q.words;
   chk_word_store_hold:
      assert property (@(posedge clk) disable iff (reset) wr && idx >= `W_FIRST |=> st_q.words[$past(idx)] == $past(data))
      else $error("descriptor word not stored");
endmodule : desc_capture
`default_nettype wire

/* File: src/cull_eval.sv */
// per-primitive facing, culling, provoking vertex and last-pixel decisions
`timescale 1ns/1ns
`default_nettype none
module cull_eval (
   setup_cfg_if.judge cfg,
   input wire setup_pkg::prim_e prim_kind,
   input wire logic prim_cw,
   input wire logic line_list,
   input wire logic line_last_seg,
   input wire logic line_diamond,
   output logic discard,
   output logic front,
   output logic [1:0] pv,
   output logic last_px
);
   import setup_pkg::*;
   always_comb begin
      front = (prim_kind == prim_tri) && (prim_cw ^ cfg.front_ccw);
      discard = 1'b0;
      if (prim_kind == prim_tri) begin
         case (cfg.cull)
            cull_all: discard = 1'b1;
            cull_nothing: discard = 1'b0;
            cull_front_facing: discard = front;
            cull_back_facing: discard = !front;
            default: discard = 1'b0;
         endcase
      end
      case (prim_kind)
         prim_tri: pv = cfg.tri_pv;
         // reserved line codes fall back to the first vertex
         prim_line: pv = cfg.line_pv[1] ? 2'h0 : cfg.line_pv;
         default: pv = 2'h0;
      endcase
      last_px = cfg.last_px_en && prim_kind == prim_line && line_diamond
         && (line_list || line_last_seg);
   end
endmodule : cull_eval
`default_nettype wire

/* File: src/setup_raster_state_decode.sv */
// setup stage state descriptor decode with per-primitive orientation decisions
`timescale 1ns/1ns
`default_nettype none
module setup_raster_state_decode (
   input wire logic clk,
   input wire logic reset,
   input wire logic desc_wr,
   input wire logic [2:0] desc_idx,
   input wire logic [31:0] desc_data,
   input wire logic [31:0] state_base,
   input wire logic fence_done,
   input wire logic prim_valid,
   input wire setup_pkg::prim_e prim_kind,
   input wire logic prim_cw,
   input wire logic line_list,
   input wire logic line_last_seg,
   input wire logic line_diamond,
   output logic [5:0] vtx_read_len,
   output logic [5:0] vtx_read_off,
   output logic [3:0] grf_start,
   output logic [6:0] max_threads,
   output logic [6:0] entry_size,
   output logic [7:0] entry_count,
   output logic fence_pending,
   output logic stats_en,
   output logic [31:0] viewport_addr,
   output logic xform_en,
   output logic aa_en,
   output logic [4:0] cap_quarter,
   output var setup_pkg::tie_e point_tie,
   output logic scissor_en,
   output logic bias_x_half,
   output logic bias_y_half,
   output logic cfg_bad,
   output logic res_valid,
   output logic res_discard,
   output logic res_front,
   output logic [1:0] res_pv,
   output logic res_last_px,
   output logic stat_inc
);
   import setup_pkg::*;

   typedef struct packed {
      fence_e fence;
      logic [5:0] vrl;
      logic [5:0] vro;
      logic [3:0] general_register_file;
      logic [6:0] thr;
      logic [5:0] esz;
      logic [7:0] ecn;
      logic stats;
      logic [31:0] vp_addr;
      logic xform;
      logic aa;
      logic [4:0] cap_q;
      tie_e tie;
      logic scis;
      logic bxh;
      logic byh;
      logic bad;
      logic r_valid;
      logic r_discard;
      logic r_front;
      logic [1:0] r_pv;
      logic r_last;
      logic r_stat;
   } st_s;

   localparam st_s ST_RST = '0;

   st_s st_q;
   st_s st_d;
   desc_t w;
   logic ev_discard;
   logic ev_front;
   logic ev_last_px;
   logic [1:0] ev_pv;
   logic [5:0] esz_new;
   logic [7:0] ecn_new;
   logic [3:0] bx;
   logic [3:0] by;
   logic bias_bad;

   setup_cfg_if cfg_bus ();

   desc_capture u_capture (
      .clk(clk),
      .reset(reset),
      .wr(desc_wr),
      .idx(desc_idx),
      .data(desc_data),
      .cfg(cfg_bus.capture)
   );

   cull_eval u_cull (
      .cfg(cfg_bus.judge),
      .prim_kind(prim_kind),
      .prim_cw(prim_cw),
      .line_list(line_list),
      .line_last_seg(line_last_seg),
      .line_diamond(line_diamond),
      .discard(ev_discard),
      .front(ev_front),
      .pv(ev_pv),
      .last_px(ev_last_px)
   );

   assign w = cfg_bus.words;
   assign cfg_bus.cull = cull_e'(w[`W_RAS][`CULL_H:`CULL_L]);
   assign cfg_bus.front_ccw = w[`W_VP][`WIND_B];
   assign cfg_bus.last_px_en = w[`W_LIN][`LPX_B];
   assign cfg_bus.tri_pv = w[`W_LIN][`TPV_H:`TPV_L];
   assign cfg_bus.line_pv = w[`W_LIN][`LPV_H:`LPV_L];

   assign esz_new = w[`W_THR][`ESZ_H:`ESZ_L];
   assign ecn_new = w[`W_THR][`ECN_H:`ECN_L];
   assign bx = w[`W_RAS][`BX_H:`BX_L];
   assign by = w[`W_RAS][`BY_H:`BY_L];
   assign bias_bad = (bx != `BIAS_ZERO && bx != `BIAS_HALF) || (by != `BIAS_ZERO && by != `BIAS_HALF);

   always_comb begin
      st_d = st_q;
      st_d.vrl = w[`W_VTX][`VRL_H:`VRL_L];
      st_d.vro = w[`W_VTX][`VRO_H:`VRO_L];
      st_d.general_register_file = w[`W_VTX][`GRF_H:`GRF_L];
      st_d.thr = {1'b0, w[`W_THR][`THR_H:`THR_L]} + 7'h01;
      st_d.stats = w[`W_THR][`STAT_B];
      st_d.vp_addr = state_base + {w[`W_VP][`VPO_H:`VPO_L], 5'h00};
      st_d.xform = w[`W_VP][`VPX_B];
      st_d.aa = w[`W_RAS][`AA_B];
      // ramp width in quarter pixels
      case (w[`W_RAS][`CAP_H:`CAP_L])
         2'h0: st_d.cap_q = 5'h02;
         2'h1: st_d.cap_q = 5'h04;
         2'h2: st_d.cap_q = 5'h08;
         2'h3: st_d.cap_q = 5'h10;
         default: st_d.cap_q = 5'h02;
      endcase
      st_d.tie = tie_e'(w[`W_RAS][`PTR_L]);
      st_d.scis = w[`W_RAS][`SCIS_B];
      st_d.bxh = bx == `BIAS_HALF;
      st_d.byh = by == `BIAS_HALF;
      // flags settings whose behaviour is undefined or reserved
      st_d.bad = w[`W_VTX][`VRL_H:`VRL_L] == 6'h00
         || w[`W_RAS][`PTR_H]
         || w[`W_LIN][`LPV_H]
         || bias_bad;
      // entry geometry only takes effect at the partition fence
      case (st_q.fence)
         fence_idle: begin
            if (esz_new != st_q.esz || ecn_new != st_q.ecn) begin
               st_d.fence = fence_wait;
            end
         end
         fence_wait: begin
            if (fence_done) begin
               st_d.esz = esz_new;
               st_d.ecn = ecn_new;
               st_d.fence = fence_idle;
            end
         end
         default: st_d.fence = fence_idle;
      endcase
      st_d.r_valid = prim_valid;
      if (prim_valid) begin
         st_d.r_discard = ev_discard;
         st_d.r_front = ev_front;
         st_d.r_pv = ev_pv;
         st_d.r_last = ev_last_px;
      end
      st_d.r_stat = prim_valid && st_q.stats;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign vtx_read_len = st_q.vrl;
   assign vtx_read_off = st_q.vro;
   assign grf_start = st_q.general_register_file;
   assign max_threads = st_q.thr;
   assign entry_size = {1'b0, st_q.esz} + 7'h01;
   assign entry_count = st_q.ecn;
   assign fence_pending = st_q.fence == fence_wait;
   assign stats_en = st_q.stats;
   assign viewport_addr = st_q.vp_addr;
   assign xform_en = st_q.xform;
   assign aa_en = st_q.aa;
   assign cap_quarter = st_q.cap_q;
   assign point_tie = st_q.tie;
   assign scissor_en = st_q.scis;
   assign bias_x_half = st_q.bxh;
   assign bias_y_half = st_q.byh;
   assign cfg_bad = st_q.bad;
   assign res_valid = st_q.r_valid;
   assign res_discard = st_q.r_discard;
   assign res_front = st_q.r_front;
   assign res_pv = st_q.r_pv;
   assign res_last_px = st_q.r_last;
   assign stat_inc = st_q.r_stat;

   chk_read_len_zero:
      assert property (@(posedge clk) disable iff (reset) !$past(reset) && vtx_read_len == 6'h00 |-> cfg_bad)
      else $error("zero read length not flagged");
   chk_read_len_field:
      assert property (@(posedge clk) disable iff (reset) !reset |=> vtx_read_len == $past(w[`W_VTX][`VRL_H:`VRL_L]))
      else $error("read length does not follow descriptor");
   chk_read_offset:
      assert property (@(posedge clk) disable iff (reset) !reset |=> vtx_read_off == $past(w[`W_VTX][`VRO_H:`VRO_L]))
      else $error("read offset does not follow descriptor");
   chk_grf_start:
      assert property (@(posedge clk) disable iff (reset) !reset |=> grf_start == $past(w[`W_VTX][`GRF_H:`GRF_L]))
      else $error("start register does not follow descriptor");
   chk_thread_limit:
      assert property (@(posedge clk) disable iff (reset) !reset |=>
         max_threads == {1'b0, $past(w[`W_THR][`THR_H:`THR_L])} + 7'h01)
      else $error("thread limit is not field plus one");
   chk_fence_commit:
      assert property (@(posedge clk) disable iff (reset) fence_pending && fence_done |=>
         !fence_pending && entry_count == $past(ecn_new) && entry_size == {1'b0, $past(esz_new)} + 7'h01)
      else $error("entry geometry not committed at fence");
   chk_fence_hold:
      assert property (@(posedge clk) disable iff (reset) fence_pending && !fence_done |=>
         $stable(entry_count) && $stable(entry_size) && fence_pending)
      else $error("entry geometry changed without fence");
   chk_stats_pulse:
      assert property (@(posedge clk) disable iff (reset) !reset |=>
         stat_inc == ($past(prim_valid) && $past(stats_en)))
      else $error("statistics pulse wrong");
   chk_viewport_addr:
      assert property (@(posedge clk) disable iff (reset) !reset |=>
         viewport_addr == $past(state_base) + {$past(w[`W_VP][`VPO_H:`VPO_L]), 5'h00} && viewport_addr[4:0] == 5'h00)
      else $error("viewport address wrong");
   chk_xform_enable:
      assert property (@(posedge clk) disable iff (reset) !reset |=> xform_en == $past(w[`W_VP][`VPX_B]))
      else $error("transform enable wrong");
   chk_front_rule:
      assert property (@(posedge clk) disable iff (reset) prim_valid && prim_kind == prim_tri |=>
         res_front == ($past(prim_cw) ^ $past(w[`W_VP][`WIND_B])))
      else $error("facing decision wrong");
   chk_cull_back:
      assert property (@(posedge clk) disable iff (reset)
         prim_valid && prim_kind == prim_tri && w[`W_RAS][`CULL_H:`CULL_L] == 2'h3 |=> res_discard == !res_front)
      else $error("back culling wrong");
   chk_cull_all:
      assert property (@(posedge clk) disable iff (reset)
         prim_valid && prim_kind == prim_tri && w[`W_RAS][`CULL_H:`CULL_L] == 2'h0 ##1 !prim_valid |-> res_discard [*2])
      else $error("cull all kept a triangle");
   chk_cull_tri_only:
      assert property (@(posedge clk) disable iff (reset) prim_valid && prim_kind != prim_tri |=> !res_discard)
      else $error("non-triangle culled");
   chk_cap_width:
      assert property (@(posedge clk) disable iff (reset) !reset |=>
         (cap_quarter == 5'h08) == ($past(w[`W_RAS][`CAP_H:`CAP_L]) == 2'h2))
      else $error("end cap width wrong");
   chk_bias_half:
      assert property (@(posedge clk) disable iff (reset) !reset |=> bias_x_half == ($past(bx) == `BIAS_HALF))
      else $error("horizontal bias wrong");
   chk_last_wide_line:
      assert property (@(posedge clk) disable iff (reset) prim_valid && !line_diamond |=> !res_last_px)
      else $error("last pixel on non-diamond line");
   chk_strip_middle:
      assert property (@(posedge clk) disable iff (reset)
         prim_valid && prim_kind == prim_line && !line_list && !line_last_seg |=> !res_last_px)
      else $error("last pixel on inner strip segment");
   chk_tri_provoke:
      assert property (@(posedge clk) disable iff (reset) prim_valid && prim_kind == prim_tri |=>
         res_pv == $past(w[`W_LIN][`TPV_H:`TPV_L]))
      else $error("triangle provoking vertex wrong");
   chk_line_provoke:
      assert property (@(posedge clk) disable iff (reset) prim_valid && prim_kind == prim_line |=> res_pv[1] == 1'b0)
      else $error("line provoking vertex out of range");
   chk_line_provoke_second:
      assert property (@(posedge clk) disable iff (reset)
         prim_valid && prim_kind == prim_line && w[`W_LIN][`LPV_H:`LPV_L] == 2'h1 |=> res_pv == 2'h1)
      else $error("line provoking vertex not second");
   chk_result_hold:
      assert property (@(posedge clk) disable iff (reset) !prim_valid |=>
         $stable(res_pv) && $stable(res_front) && $stable(res_discard) && !res_valid)
      else $error("primitive result changed without a primitive");
   chk_cull_none:
      assert property (@(posedge clk) disable iff (reset)
         prim_valid && prim_kind == prim_tri && w[`W_RAS][`CULL_H:`CULL_L] == 2'h1 |=> !res_discard)
      else $error("cull none dropped a triangle");
   chk_cull_front:
      assert property (@(posedge clk) disable iff (reset)
         prim_valid && prim_kind == prim_tri && w[`W_RAS][`CULL_H:`CULL_L] == 2'h2 |=> res_discard == res_front)
      else $error("front culling wrong");
   chk_stats_off:
      assert property (@(posedge clk) disable iff (reset) !stats_en |=> !stat_inc)
      else $error("counter pulse while statistics off");
   chk_point_tie_right:
      assert property (@(posedge clk) disable iff (reset)
         !reset && w[`W_RAS][`PTR_H:`PTR_L] == 2'h1 |=> point_tie == tie_rule_top_right)
      else $error("point tie rule not top right");
   chk_point_tie_reserved:
      assert property (@(posedge clk) disable iff (reset) w[`W_RAS][`PTR_H] |=> cfg_bad)
      else $error("reserved point tie rule not flagged");
   chk_bias_vertical:
      assert property (@(posedge clk) disable iff (reset) !reset |=> bias_y_half == ($past(by) == `BIAS_HALF))
      else $error("vertical bias wrong");
   chk_last_list_line:
      assert property (@(posedge clk) disable iff (reset) prim_valid && prim_kind == prim_line && line_diamond
         && line_list && w[`W_LIN][`LPX_B] |=> res_last_px)
      else $error("last pixel missing on list line");
   chk_fence_raise:
      assert property (@(posedge clk) disable iff (reset) !fence_pending && ecn_new != entry_count |=> fence_pending)
      else $error("entry count change did not wait for fence");

   cov_tri_culled:
      cover property (@(posedge clk) disable iff (reset) res_valid && res_discard);
   cov_fence_commit:
      cover property (@(posedge clk) disable iff (reset) fence_pending ##1 !fence_pending);
   cov_last_pixel:
      cover property (@(posedge clk) disable iff (reset) res_valid && res_last_px);
   cov_stat_count:
      cover property (@(posedge clk) disable iff (reset) stat_inc [*2]);
   cov_line_second:
      cover property (@(posedge clk) disable iff (reset) res_valid && res_pv == 2'h1);
endmodule : setup_raster_state_decode
`default_nettype wire

/* File: tb/setup_raster_state_decode_tb.sv */
// self-checking bench for the setup state descriptor decode block
`timescale 1ns/1ns
`default_nettype none
module setup_raster_state_decode_tb;
   import setup_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic desc_wr = 1'b0;
   logic [2:0] desc_idx = 3'h0;
   logic [31:0] desc_data = 32'h0;
   logic [31:0] state_base = 32'h0001_0000;
   logic fence_done = 1'b0;
   logic prim_valid = 1'b0;
   prim_e prim_kind = prim_point;
   logic prim_cw = 1'b0;
   logic line_list = 1'b0;
   logic line_last_seg = 1'b0;
   logic line_diamond = 1'b0;
   logic [5:0] vtx_read_len, vtx_read_off;
   logic [3:0] grf_start;
   logic [6:0] max_threads, entry_size;
   logic [7:0] entry_count;
   logic [31:0] viewport_addr;
   logic [4:0] cap_quarter;
   tie_e point_tie;
   logic fence_pending, stats_en, xform_en, aa_en, scissor_en, bias_x_half, bias_y_half, cfg_bad;
   logic res_valid, res_discard, res_front, res_last_px, stat_inc;
   logic [1:0] res_pv;
   int error_cnt = 0;
   int comparisons = 0;

   always #4 clk = ~clk;

   setup_raster_state_decode setup_raster_state_decode_inst (
      .clk(clk), .reset(reset), .desc_wr(desc_wr), .desc_idx(desc_idx), .desc_data(desc_data),
      .state_base(state_base), .fence_done(fence_done), .prim_valid(prim_valid), .prim_kind(prim_kind),
      .prim_cw(prim_cw), .line_list(line_list), .line_last_seg(line_last_seg), .line_diamond(line_diamond),
      .vtx_read_len(vtx_read_len), .vtx_read_off(vtx_read_off), .grf_start(grf_start),
      .max_threads(max_threads), .entry_size(entry_size), .entry_count(entry_count),
      .fence_pending(fence_pending), .stats_en(stats_en), .viewport_addr(viewport_addr),
      .xform_en(xform_en), .aa_en(aa_en), .cap_quarter(cap_quarter), .point_tie(point_tie),
      .scissor_en(scissor_en), .bias_x_half(bias_x_half), .bias_y_half(bias_y_half), .cfg_bad(cfg_bad),
      .res_valid(res_valid), .res_discard(res_discard), .res_front(res_front), .res_pv(res_pv),
      .res_last_px(res_last_px), .stat_inc(stat_inc)
   );

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // one word per call; decoded outputs other than the fence-gated entry_size and entry_count are settled when it returns
   task automatic wr_word(input logic [2:0] idx, input logic [31:0] data);
      @(posedge clk);
      desc_wr <= 1'b1;
      desc_idx <= idx;
      desc_data <= data;
      @(posedge clk);
      desc_wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask : wr_word

   task automatic prim(input prim_e k, input logic cw, input logic [2:0] ln);
      @(posedge clk);
      prim_valid <= 1'b1;
      prim_kind <= k;
      prim_cw <= cw;
      {line_list, line_last_seg, line_diamond} <= ln;
      @(posedge clk);
      prim_valid <= 1'b0;
      #1;
      check("res_valid", res_valid, 1'b1);
   endtask : prim

   task automatic t_reset;
      check("entry_size", entry_size, 7'h01);
      check("max_threads", max_threads, 7'h01);
      check("cap_quarter", cap_quarter, 5'h02);
      check("fence_pending", fence_pending, 1'b0);
      check("cfg_bad", cfg_bad, 1'b1);
   endtask : t_reset

   task automatic t_vertex;
      wr_word(3'h3, {15'h0, 6'h3f, 1'b0, 6'h2a, 4'hf});
      check("vtx_read_len", vtx_read_len, 6'h3f);
      check("vtx_read_off", vtx_read_off, 6'h2a);
      check("grf_start", grf_start, 4'hf);
      check("cfg_bad", cfg_bad, 1'b0);
      wr_word(3'h1, 32'hffff_ffff);
      check("vtx_read_len", vtx_read_len, 6'h3f);
      wr_word(3'h3, {15'h0, 6'h00, 1'b0, 6'h15, 4'h0});
      check("cfg_bad", cfg_bad, 1'b1);
      wr_word(3'h3, {15'h0, 6'h01, 1'b0, 6'h00, 4'h0});
      check("vtx_read_len", vtx_read_len, 6'h01);
      check("vtx_read_off", vtx_read_off, 6'h00);
   endtask : t_vertex

   task automatic t_fence;
      @(posedge clk);
      fence_done <= 1'b1;
      wr_word(3'h4, {1'b0, 6'h2f, 6'h3f, 8'h80, 1'b1, 10'h0});
      fence_done <= 1'b0;
      check("max_threads", max_threads, 7'h30);
      check("stats_en", stats_en, 1'b1);
      check("fence_pending", fence_pending, 1'b1);
      check("entry_size", entry_size, 7'h01);
      @(posedge clk);
      fence_done <= 1'b1;
      @(posedge clk);
      fence_done <= 1'b0;
      #1;
      for (int i = 0; i < 4 && fence_pending !== 1'b0; i++) @(posedge clk) #1;
      if (fence_pending !== 1'b0) begin
         error_cnt++;
         print_verdict();
      end
      check("entry_size", entry_size, 7'h40);
      check("entry_count", entry_count, 8'h80);
   endtask : t_fence

   task automatic t_viewport;
      wr_word(3'h5, 32'h0000_1243);
      check("viewport_addr", viewport_addr, 32'h0001_1240);
      check("xform_en", xform_en, 1'b1);
      wr_word(3'h5, 32'hffff_ffe0);
      check("viewport_addr", viewport_addr, 32'h0000_ffe0);
      check("xform_en", xform_en, 1'b0);
   endtask : t_viewport

   task automatic t_raster;
      logic [1:0] c;
      for (int n = 0; n < 4; n++) begin
         c = n[1:0];
         wr_word(3'h6, {c[0], c, 5'h0, c, c, 2'h0, c[1], c[0] ? 4'h8 : 4'h0, c[1] ? 4'h8 : 4'h0, 9'h0});
         check("aa_en", aa_en, c[0]);
         check("cap_quarter", cap_quarter, 5'h02 << c);
         check("point_tie", point_tie, c[0]);
         check("scissor_en", scissor_en, c[1]);
         check("bias_x_half", bias_x_half, c[0]);
         check("bias_y_half", bias_y_half, c[1]);
         check("cfg_bad", cfg_bad, c[1]);
      end
      wr_word(3'h6, 32'h0000_8000);
      check("cfg_bad", cfg_bad, 1'b1);
      wr_word(3'h6, 32'h0000_0800);
      check("cfg_bad", cfg_bad, 1'b1);
   endtask : t_raster

   task automatic t_cull;
      logic f;
      logic d;
      for (int w = 0; w < 2; w++) begin
         wr_word(3'h5, {31'h0, w[0]});
         for (int cm = 0; cm < 4; cm++) begin
            wr_word(3'h6, {1'b0, cm[1:0], 29'h0});
            for (int cw = 0; cw < 2; cw++) begin
               f = cw[0] ^ w[0];
               d = (cm == 0) || (cm == 2 && f) || (cm == 3 && !f);
               prim(prim_tri, cw[0], 3'h0);
               check("res_front", res_front, f);
               check("res_discard", res_discard, d);
               check("stat_inc", stat_inc, 1'b1);
            end
            for (int k = 0; k < 4; k++) begin
               if (k != 2) begin
                  prim(prim_e'(k), 1'b1, 3'h7);
                  check("res_discard", res_discard, 1'b0);
               end
            end
         end
      end
      wr_word(3'h4, {1'b0, 6'h2f, 6'h3f, 8'h80, 1'b0, 10'h0});
      prim(prim_tri, 1'b0, 3'h0);
      check("stat_inc", stat_inc, 1'b0);
      @(posedge clk);
      #1;
      check("res_valid", res_valid, 1'b0);
   endtask : t_cull

   task automatic t_last_px;
      wr_word(3'h7, 32'h8000_0000);
      for (int n = 0; n < 8; n++) begin
         prim(prim_line, 1'b0, n[2:0]);
         check("res_last_px", res_last_px, n[0] & (n[2] | n[1]));
      end
      prim(prim_tri, 1'b0, 3'h7);
      check("res_last_px", res_last_px, 1'b0);
      wr_word(3'h7, 32'h0000_0000);
      prim(prim_line, 1'b0, 3'h7);
      check("res_last_px", res_last_px, 1'b0);
   endtask : t_last_px

   task automatic t_pv;
      for (int v = 0; v < 4; v++) begin
         wr_word(3'h7, {1'b0, v[1:0], v[1:0], 27'h0});
         prim(prim_tri, 1'b0, 3'h0);
         check("res_pv", res_pv, v[1:0]);
         prim(prim_line, 1'b0, 3'h0);
         check("res_pv", res_pv, v[1] ? 2'h0 : v[1:0]);
         check("cfg_bad", cfg_bad, v[1]);
      end
   endtask : t_pv

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_vertex();
      t_fence();
      t_viewport();
      t_raster();
      t_cull();
      t_last_px();
      t_pv();
      print_verdict();
   end
endmodule : setup_raster_state_decode_tb
`default_nettype wire
